//--- core/smsr_regs.sv
// sensor mode and status register bank: product identifier, operating
// state, buffer gate error and gate count, wake level output.
// assumes an avalon-mm master on mclk_i, buffer and rate events from
// logic on the same clock, strap and trigger from pins.
`timescale 1ns/1ps
`include "smsr_consts.svh"

module smsr_regs
    import smsr_pkg::*;
(
    input  wire logic        mclk_i,            // 40 MHz system clock
    input  wire logic        nrst_i,            // async reset, active low
    // avalon-mm slave
    input  wire logic [9:0]  avs_address_i,     // byte address
    input  wire logic        avs_read_i,        // read request
    input  wire logic        avs_write_i,       // write request
    input  wire logic [31:0] avs_writedata_i,   // write data
    input  wire logic [3:0]  avs_byteenable_i,  // byte lanes
    output logic      [31:0] avs_readdata_o,    // read data, registered
    output logic             avs_waitrequest_o, // stall
    // pins
    input  wire logic        boot_strap_pin_i,  // boot mode strap
    input  wire logic        trig_pin_i,        // external trigger
    // same-clock inputs
    input  wire logic        motion_detect_select_i, // boot motion select
    input  wire smsr_buf_ev_t buf_ev_i,         // buffer events
    input  wire logic        output_rate_tick_i, // one pulse per period
    input  wire logic        sleep_req_i,       // auto sleep request
    input  wire logic        meas_done_i,       // triggered sample done
    // outputs
    output smsr_wake_pins_t  wake_pins_o,       // wake levels, registered
    output logic             debounce_clr_o     // one-cycle pulse
);

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [1:0] pins_s;

    smsr_sync2 #(.WIDTH(2)) u_sync
    (
        .mclk_i (mclk_i),
        .nrst_i (nrst_i),
        .d_i    ({boot_strap_pin_i, trig_pin_i}),
        .q_o    (pins_s)
    );

    logic strap_s;
    logic trig_s;
    assign strap_s = pins_s[1];
    assign trig_s  = pins_s[0];

    // ------------------------------------------------------------
    // state declarations
    // ------------------------------------------------------------
    logic [1:0]                 boot_cnt_r, boot_cnt_nxt;
    logic                       booted_r,   booted_nxt;
    logic                       strap_r,    strap_nxt;
    logic                       trig_d_r,   trig_d_nxt;
    smsr_state_t                state_r,    state_nxt;
    logic [`SMSR_CTL_WIDTH-1:0] ctl_r,      ctl_nxt;
    logic                       err_r,      err_nxt;
    logic [4:0]                 cnt_r,      cnt_nxt;
    logic                       ack_r,      ack_nxt;
    logic [31:0]                rdata_r,    rdata_nxt;
    smsr_wake_pins_t            pins_r,     pins_nxt;
    logic                       dbc_r,      dbc_nxt;

    logic       req;
    logic       hit_aligned;
    logic [7:0] idx;
    logic       wr_ctl;
    logic       go_active;
    logic       clr_ev;
    smsr_code_t code;

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    // one wait state per access so read data can come from a flop;
    // a write lands only on the edge where waitrequest is seen low
    assign req               = avs_read_i | avs_write_i;
    assign avs_waitrequest_o = req & ~ack_r;
    assign idx               = avs_address_i[9:2];
    assign hit_aligned       = (avs_address_i[1:0] == 2'h0);
    assign wr_ctl            = avs_write_i & ack_r & hit_aligned
                             & (idx == `SMSR_IDX_CONTROL)
                             & avs_byteenable_i[0];

    // the visible code, trigger measurement reads as wake
    always_comb
    begin
        case (state_r)
            SMSR_ST_STANDBY:   code = SMSR_CODE_STANDBY;
            SMSR_ST_WAKE:      code = SMSR_CODE_WAKE;
            SMSR_ST_SLEEP:     code = SMSR_CODE_SLEEP;
            SMSR_ST_TRIG_WAIT: code = SMSR_CODE_TRIG;
            SMSR_ST_TRIG_MEAS: code = SMSR_CODE_WAKE;
            default:           code = SMSR_CODE_STANDBY;
        endcase
    end

    // ------------------------------------------------------------
    // boot strap capture
    // ------------------------------------------------------------
    // waits for the synchroniser to fill before the strap is trusted
    always_comb
    begin
        boot_cnt_nxt = boot_cnt_r;
        booted_nxt   = booted_r;
        strap_nxt    = strap_r;
        if (!booted_r)
        begin
            if (boot_cnt_r == `SMSR_BOOT_WAIT)
            begin
                booted_nxt = 1'b1;
                strap_nxt  = strap_s;
            end
            else
            begin
                boot_cnt_nxt = boot_cnt_r + 2'h1;
            end
        end
    end

    always_ff @(posedge mclk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            boot_cnt_r <= 2'h0;
            booted_r   <= 1'b0;
            strap_r    <= 1'b0;
        end
        else
        begin
            boot_cnt_r <= boot_cnt_nxt;
            booted_r   <= booted_nxt;
            strap_r    <= strap_nxt;
        end
    end

    // ------------------------------------------------------------
    // control register and operating state
    // ------------------------------------------------------------
    // active bit leaving zero is the standby to active transition
    assign go_active = (state_r == SMSR_ST_STANDBY)
                     & ctl_nxt[`SMSR_CTL_ACTIVE];

    always_comb
    begin
        ctl_nxt    = ctl_r;
        state_nxt  = state_r;
        trig_d_nxt = trig_s;
        dbc_nxt    = 1'b0;
        if (wr_ctl)
            ctl_nxt = avs_writedata_i[`SMSR_CTL_WIDTH-1:0];
        if (!booted_r)
        begin
            if ((boot_cnt_r == `SMSR_BOOT_WAIT) && strap_s
                && motion_detect_select_i)
            begin
                ctl_nxt[`SMSR_CTL_ACTIVE] = 1'b1;
                state_nxt                 = SMSR_ST_WAKE;
            end
        end
        else if (!ctl_nxt[`SMSR_CTL_ACTIVE])
        begin
            state_nxt = SMSR_ST_STANDBY;
        end
        else
        begin
            case (state_r)
                SMSR_ST_STANDBY:
                    if (ctl_nxt[`SMSR_CTL_TRIG_FUNC] && !strap_r)
                        state_nxt = SMSR_ST_TRIG_WAIT;
                    else
                        state_nxt = SMSR_ST_WAKE;
                SMSR_ST_WAKE:
                    if (sleep_req_i)
                        state_nxt = SMSR_ST_SLEEP;
                SMSR_ST_SLEEP:
                    if (!sleep_req_i)
                        state_nxt = SMSR_ST_WAKE;
                SMSR_ST_TRIG_WAIT:
                    if (trig_s && !trig_d_r)
                        state_nxt = SMSR_ST_TRIG_MEAS;
                SMSR_ST_TRIG_MEAS:
                    if (meas_done_i)
                        state_nxt = SMSR_ST_TRIG_WAIT;
                default:
                    state_nxt = SMSR_ST_STANDBY;
            endcase
        end
        if ((state_nxt != state_r)
            && (state_nxt != SMSR_ST_STANDBY)
            && (state_nxt != SMSR_ST_TRIG_MEAS)
            && (state_r != SMSR_ST_TRIG_MEAS))
            dbc_nxt = 1'b1;
    end

    always_ff @(posedge mclk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            ctl_r    <= `SMSR_CTL_RESET;
            state_r  <= SMSR_ST_STANDBY;
            trig_d_r <= 1'b0;
            dbc_r    <= 1'b0;
        end
        else
        begin
            ctl_r    <= ctl_nxt;
            state_r  <= state_nxt;
            trig_d_r <= trig_d_nxt;
            dbc_r    <= dbc_nxt;
        end
    end

    assign debounce_clr_o = dbc_r;

    // ------------------------------------------------------------
    // buffer gate error and gate count
    // ------------------------------------------------------------
    // clearing events
    assign clr_ev = buf_ev_i.empty | buf_ev_i.flush | buf_ev_i.mode_off
                  | (booted_r & go_active);

    // a set in the same cycle as a clear wins
    always_comb
    begin
        err_nxt = err_r;
        cnt_nxt = cnt_r;
        if (clr_ev)
        begin
            err_nxt = 1'b0;
            cnt_nxt = 5'h00;
        end
        if (buf_ev_i.gate_en && buf_ev_i.sample && !buf_ev_i.empty)
            err_nxt = 1'b1;
        if (err_r && !clr_ev && output_rate_tick_i)
        begin
            if (cnt_r != `SMSR_CNT_MAX)
                cnt_nxt = cnt_r + 5'h01;
        end
    end

    always_ff @(posedge mclk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            err_r <= 1'b0;
            cnt_r <= 5'h00;
        end
        else
        begin
            err_r <= err_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    // ------------------------------------------------------------
    // wake level pins
    // ------------------------------------------------------------
    // pins only driven while the wake level is wanted
    always_comb
    begin
        pins_nxt = '0;
        if (ctl_r[`SMSR_CTL_WAKE_OUT_EN] && (code == SMSR_CODE_WAKE))
        begin
            if (ctl_r[`SMSR_CTL_PIN_CHOICE])
            begin
                pins_nxt.b_oe  = 1'b1;
                pins_nxt.b_lvl = ctl_r[`SMSR_CTL_POLARITY];
            end
            else
            begin
                pins_nxt.a_oe  = 1'b1;
                pins_nxt.a_lvl = ctl_r[`SMSR_CTL_POLARITY];
            end
        end
    end

    always_ff @(posedge mclk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            pins_r <= '0;
        else
            pins_r <= pins_nxt;
    end

    assign wake_pins_o = pins_r;

    // ------------------------------------------------------------
    // bus answer and read data
    // ------------------------------------------------------------
    // unmapped or misaligned reads return zero, writes there vanish
    always_comb
    begin
        ack_nxt   = req & ~ack_r;
        rdata_nxt = rdata_r;
        if (avs_read_i && ack_nxt)
        begin
            rdata_nxt = 32'h0000_0000;
            if (hit_aligned)
            begin
                case (idx)
                    `SMSR_IDX_PRODUCT_ID:
                        rdata_nxt[7:0] = `SMSR_PRODUCT_ID_VAL;
                    `SMSR_IDX_SYS_STATUS:
                    begin
                        rdata_nxt[`SMSR_ERR_BIT] = err_r;
                        rdata_nxt[`SMSR_CNT_MSB:`SMSR_CNT_LSB] = cnt_r;
                        rdata_nxt[`SMSR_MODE_MSB:`SMSR_MODE_LSB] = code;
                    end
                    `SMSR_IDX_CONTROL:
                        rdata_nxt[`SMSR_CTL_WIDTH-1:0] = ctl_r;
                    default:
                        rdata_nxt = 32'h0000_0000;
                endcase
            end
        end
    end

    always_ff @(posedge mclk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            ack_r   <= 1'b0;
            rdata_r <= 32'h0000_0000;
        end
        else
        begin
            ack_r   <= ack_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    assign avs_readdata_o = rdata_r;

endmodule : smsr_regs

//--- core/smsr_consts.svh
// offsets, field positions, reset values and timing counts of the
// sensor mode and status register bank.
// assumes inclusion by bare name from the package and the top module.
`ifndef SMSR_CONSTS_SVH
`define SMSR_CONSTS_SVH

// ----------------------------------------------------------------
// register indices, byte address is four times the index
// ----------------------------------------------------------------
`define SMSR_IDX_PRODUCT_ID   8'h13
`define SMSR_IDX_SYS_STATUS   8'h14
`define SMSR_IDX_CONTROL      8'h20

// ----------------------------------------------------------------
// status register field positions
// ----------------------------------------------------------------
`define SMSR_ERR_BIT          7
`define SMSR_CNT_MSB          6
`define SMSR_CNT_LSB          2
`define SMSR_MODE_MSB         1
`define SMSR_MODE_LSB         0

// ----------------------------------------------------------------
// control register field positions
// ----------------------------------------------------------------
`define SMSR_CTL_ACTIVE       0
`define SMSR_CTL_TRIG_FUNC    1
`define SMSR_CTL_WAKE_OUT_EN  2
`define SMSR_CTL_PIN_CHOICE   3
`define SMSR_CTL_POLARITY     4
`define SMSR_CTL_WIDTH        5
`define SMSR_CTL_RESET        5'h00

// ----------------------------------------------------------------
// reset values and timing
// ----------------------------------------------------------------
// identifier value is arbitrary, chosen only to be recognisable
`define SMSR_PRODUCT_ID_VAL   8'h5A
`define SMSR_CNT_MAX          5'h1F
`define SMSR_BOOT_WAIT        2'h3

`endif

//--- core/smsr_pkg.sv
// types shared by the sensor mode and status register bank.
// assumes the constants header sits beside it on the include path.
`include "smsr_consts.svh"

package smsr_pkg;

    // operating state code as software reads it
    typedef enum logic [1:0]
    {
        SMSR_CODE_STANDBY = 2'b00,
        SMSR_CODE_WAKE    = 2'b01,
        SMSR_CODE_SLEEP   = 2'b10,
        SMSR_CODE_TRIG    = 2'b11
    } smsr_code_t;

    // internal state, the trigger measurement shows as wake
    typedef enum logic [2:0]
    {
        SMSR_ST_STANDBY   = 3'b000,
        SMSR_ST_WAKE      = 3'b001,
        SMSR_ST_SLEEP     = 3'b010,
        SMSR_ST_TRIG_WAIT = 3'b011,
        SMSR_ST_TRIG_MEAS = 3'b100
    } smsr_state_t;

    // events arriving from the output buffer logic
    typedef struct packed
    {
        logic gate_en;    // buffer gating enabled
        logic sample;     // next xyz sample arrives
        logic empty;      // buffer count is zero
        logic flush;      // buffer flush written
        logic mode_off;   // buffer mode set to 00b
    } smsr_buf_ev_t;

    // wake level driven onto the two irq pins
    typedef struct packed
    {
        logic a_lvl;
        logic a_oe;
        logic b_lvl;
        logic b_oe;
    } smsr_wake_pins_t;

endpackage : smsr_pkg

//--- core/smsr_sync2.sv
// two flip-flop synchroniser for pin inputs of the register bank.
// assumes the input is asynchronous to mclk_i; first stage read only
// by the second.
`timescale 1ns/1ps

module smsr_sync2
#(
    parameter int WIDTH = 1
)
(
    input  wire logic             mclk_i,  // system clock
    input  wire logic             nrst_i,  // async reset, active low
    input  wire logic [WIDTH-1:0] d_i,     // asynchronous level
    output logic      [WIDTH-1:0] q_o      // synchronised level
);

    logic [WIDTH-1:0] meta_r;
    logic [WIDTH-1:0] q_r;

    // elaboration check, a zero-width stage has nothing to carry
    if (WIDTH < 1)
    begin : g_width_check
        $error("smsr_sync2: WIDTH must be at least 1");
    end

    // both stages clear at reset, no port reaches the reset branch
    always_ff @(posedge mclk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            meta_r <= '0;
            q_r    <= '0;
        end
        else
        begin
            meta_r <= d_i;
            q_r    <= meta_r;
        end
    end

    assign q_o = q_r;

endmodule : smsr_sync2

//--- sim/smsr_chk_sva.sv
// bus, readback and wake pin checks of the mode and status bank.
// assumes one clock domain and the one-wait-cycle bus of the bank.
`timescale 1ns/1ps
`include "smsr_consts.svh"

module smsr_chk
    import smsr_pkg::*;
(
    input  wire logic            mclk_i,            // system clock
    input  wire logic            nrst_i,            // reset, active low
    input  wire logic [9:0]      avs_address_i,     // byte address
    input  wire logic            avs_read_i,        // read request
    input  wire logic            avs_write_i,       // write request
    input  wire logic [31:0]     avs_readdata_o,    // read data
    input  wire logic            avs_waitrequest_o, // stall
    input  wire smsr_wake_pins_t wake_pins_o,       // wake levels
    input  wire logic            debounce_clr_o     // debounce pulse
);
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!nrst_i);

    // ------------------------------------------------------------
    // bus timing, readback, wake pins and boot debounce quiet
    // ------------------------------------------------------------
    logic rd_take;
    // a read is taken on the edge where it still stalls
    assign rd_take = avs_read_i && avs_waitrequest_o;

    a_wait_once: assert property ( // BUS
        (avs_read_i || avs_write_i) && avs_waitrequest_o
        |=> !avs_waitrequest_o) else $error("second wait cycle");
    a_wait_idle: assert property ( // BUS
        !(avs_read_i || avs_write_i) |-> !avs_waitrequest_o)
        else $error("stall without request");
    a_id_value: assert property (
        rd_take && avs_address_i == 10'h04C
        |=> avs_readdata_o == {24'h000000, `SMSR_PRODUCT_ID_VAL})
        else $error("identifier value wrong");
    a_status_upper: assert property (
        rd_take && avs_address_i == 10'h050
        |=> avs_readdata_o[31:8] == 24'h000000)
        else $error("status upper bits set");
    a_unmapped_zero: assert property ( // BUS
        rd_take && avs_address_i == 10'h000 |=> avs_readdata_o == 32'h0)
        else $error("unmapped read not zero");
    a_read_hold: assert property ( // BUS
        !rd_take |=> $stable(avs_readdata_o))
        else $error("read data moved");
    a_pin_exclusive: assert property (
        !(wake_pins_o.a_oe && wake_pins_o.b_oe))
        else $error("both wake pins driven");
    a_pin_idle_low: assert property (
        (wake_pins_o.a_oe || !wake_pins_o.a_lvl)
        && (wake_pins_o.b_oe || !wake_pins_o.b_lvl))
        else $error("undriven pin level high");
    a_boot_quiet: assert property (
        $rose(nrst_i) |-> !debounce_clr_o [*3])
        else $error("debounce pulse during boot wait");

    c_id_read: cover property (rd_take && avs_address_i == 10'h04C);
    c_pin_b: cover property (wake_pins_o.b_oe);
    c_debounce: cover property (debounce_clr_o);
endmodule : smsr_chk

bind smsr_regs smsr_chk u_smsr_chk
(
    .mclk_i            (mclk_i),
    .nrst_i            (nrst_i),
    .avs_address_i     (avs_address_i),
    .avs_read_i        (avs_read_i),
    .avs_write_i       (avs_write_i),
    .avs_readdata_o    (avs_readdata_o),
    .avs_waitrequest_o (avs_waitrequest_o),
    .wake_pins_o       (wake_pins_o),
    .debounce_clr_o    (debounce_clr_o)
);

//--- sim/smsr_host.sv
// avalon-mm host model that reads and writes the register bank.
// assumes one clock; the bench calls its transfer task.
`timescale 1ns/1ps

module smsr_host
(
    input  wire logic        mclk_i,  // system clock
    input  wire logic [31:0] rdata_i, // read data
    input  wire logic        wait_i,  // waitrequest
    output logic      [9:0]  addr_o,  // byte address
    output logic             rd_o,    // read request
    output logic             wr_o,    // write request
    output logic      [31:0] wdata_o, // write data
    output logic      [3:0]  be_o     // byte lanes
);
    // ------------------------------------------------------------
    // transfers
    // ------------------------------------------------------------
    // idle lines carry inverted values so stale data is never reused
    initial
    begin
        addr_o  = 10'h3FF;
        rd_o    = 1'b0;
        wr_o    = 1'b0;
        wdata_o = 32'hFFFFFFFF;
        be_o    = 4'h0;
    end

    // request held until waitrequest is sampled low at an edge
    task automatic xfer(input logic w, input logic [9:0] a,
                        input logic [31:0] wd, input logic [3:0] b,
                        output logic [31:0] d);
        @(posedge mclk_i);
        addr_o  <= a;
        wdata_o <= wd;
        be_o    <= b;
        rd_o    <= !w;
        wr_o    <= w;
        @(posedge mclk_i);
        while (wait_i !== 1'b0)
            @(posedge mclk_i);
        d = rdata_i;
        rd_o    <= 1'b0;
        wr_o    <= 1'b0;
        addr_o  <= ~a;
        wdata_o <= ~wd;
        be_o    <= 4'h0;
    endtask : xfer
endmodule : smsr_host

//--- sim/tb.sv
// self-checking bench of the mode and status register bank.
// assumes the host model and the bound checker are compiled with it.
`timescale 1ns/1ps
`include "smsr_consts.svh"

module tb;
    import smsr_pkg::*;
    logic            mclk_i;
    logic            nrst_i;
    logic            strap, trig, motion, sleep_req, meas, tick;
    logic [9:0]      adr;
    logic            rd_s, wr_s, waitreq, dbc;
    logic [31:0]     wdat, rdat, d;
    logic [3:0]      be;
    smsr_buf_ev_t    bev;
    smsr_wake_pins_t pins;
    int              fails, cmp_count, dbc_n, n;

    smsr_regs u_smsr_regs (.mclk_i(mclk_i), .nrst_i(nrst_i),
        .avs_address_i(adr), .avs_read_i(rd_s), .avs_write_i(wr_s),
        .avs_writedata_i(wdat), .avs_byteenable_i(be),
        .avs_readdata_o(rdat), .avs_waitrequest_o(waitreq),
        .boot_strap_pin_i(strap), .trig_pin_i(trig),
        .motion_detect_select_i(motion), .buf_ev_i(bev),
        .output_rate_tick_i(tick), .sleep_req_i(sleep_req),
        .meas_done_i(meas), .wake_pins_o(pins), .debounce_clr_o(dbc));
    smsr_host u_smsr_host (.mclk_i(mclk_i), .rdata_i(rdat),
        .wait_i(waitreq), .addr_o(adr), .rd_o(rd_s), .wr_o(wr_s),
        .wdata_o(wdat), .be_o(be));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic wt(input int c);
        repeat (c) @(posedge mclk_i);
    endtask : wt
    task automatic ck(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e)
        begin
            fails++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
        end
    endtask : ck
    task automatic wr(input logic [9:0] a, input logic [31:0] v,
                      input logic [3:0] b);
        logic [31:0] x;
        u_smsr_host.xfer(1'b1, a, v, b, x);
    endtask : wr
    task automatic ctl(input logic [31:0] v);
        wr(10'h080, v, 4'hF);
        wt(3);
    endtask : ctl
    // status byte built from error flag, count and state code
    task automatic cs(input logic e, input logic [4:0] c,
                      input smsr_code_t m);
        u_smsr_host.xfer(1'b0, 10'h050, 32'h0, 4'hF, d);
        ck(d, {24'h000000, e, c, m});
    endtask : cs
    // one-cycle pulse on chosen buffer event lines
    task automatic pl(input logic [4:0] m);
        bev <= bev | m;
        wt(1);
        bev <= bev & ~m;
        wt(1);
    endtask : pl
    task automatic rst(input logic s, input logic m);
        nrst_i <= 1'b0;
        strap  <= s;
        motion <= m;
        wt(4);
        nrst_i <= 1'b1;
        wt(10);
    endtask : rst

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_boot;
        rst(1'b0, 1'b1);
        cs(1'b0, 5'h00, SMSR_CODE_STANDBY);
        n = dbc_n;
        rst(1'b1, 1'b1);
        cs(1'b0, 5'h00, SMSR_CODE_WAKE);
        ck(dbc_n - n, 1);
        rst(1'b1, 1'b0);
        cs(1'b0, 5'h00, SMSR_CODE_STANDBY);
        $display("boot test done");
    endtask : t_boot
    task automatic t_regs;
        rst(1'b0, 1'b0);
        u_smsr_host.xfer(1'b0, 10'h04C, 32'h0, 4'hF, d);
        ck(d, {24'h0, `SMSR_PRODUCT_ID_VAL});
        wr(10'h04C, 32'h000000A5, 4'hF);
        wr(10'h050, 32'h000000FF, 4'hF);
        wr(10'h080, 32'h00000001, 4'hE);
        u_smsr_host.xfer(1'b0, 10'h04C, 32'h0, 4'hF, d);
        ck(d, {24'h0, `SMSR_PRODUCT_ID_VAL});
        cs(1'b0, 5'h00, SMSR_CODE_STANDBY);
        u_smsr_host.xfer(1'b0, 10'h000, 32'h0, 4'hF, d);
        ck(d, 32'h0);
        $display("register test done");
    endtask : t_regs
    task automatic t_modes;
        ctl(32'h1);
        cs(1'b0, 5'h00, SMSR_CODE_WAKE);
        n = dbc_n;
        sleep_req <= 1'b1;
        wt(3);
        cs(1'b0, 5'h00, SMSR_CODE_SLEEP);
        ck(dbc_n - n, 1);
        sleep_req <= 1'b0;
        ctl(32'h0);
        cs(1'b0, 5'h00, SMSR_CODE_STANDBY);
        ctl(32'h3);
        cs(1'b0, 5'h00, SMSR_CODE_TRIG);
        repeat (2)
        begin
            trig <= 1'b1;
            wt(6);
            cs(1'b0, 5'h00, SMSR_CODE_WAKE);
            trig <= 1'b0;
            meas <= 1'b1;
            wt(1);
            meas <= 1'b0;
            wt(2);
            cs(1'b0, 5'h00, SMSR_CODE_TRIG);
        end
        // the strap is only trusted at boot, so reboot with it high
        rst(1'b1, 1'b0);
        ctl(32'h3);
        cs(1'b0, 5'h00, SMSR_CODE_WAKE);
        ctl(32'h0);
        strap <= 1'b0;
        $display("mode test done");
    endtask : t_modes
    task automatic t_pins;
        ctl(32'h1D);
        ck(32'(pins), 32'h3);
        ctl(32'h0);
        ctl(32'h05);
        ck(32'(pins), 32'h4);
        sleep_req <= 1'b1;
        wt(3);
        ck(32'(pins), 32'h0);
        sleep_req <= 1'b0;
        ctl(32'h0);
        $display("wake pin test done");
    endtask : t_pins
    task automatic t_gate;
        ctl(32'h1);
        bev.gate_en <= 1'b1;
        wt(1);
        for (int k = 0; k < 4; k++)
        begin
            pl(5'h08);
            repeat (2) pl(5'h00) ;
            tick <= 1'b1;
            wt(2);
            tick <= 1'b0;
            wt(1);
            cs(1'b1, 5'h02, SMSR_CODE_WAKE);
            case (k)
                0: pl(5'h04);
                1: pl(5'h02);
                2: pl(5'h01);
                default: begin ctl(32'h0); ctl(32'h1); end
            endcase
            cs(1'b0, 5'h00, SMSR_CODE_WAKE);
        end
        pl(5'h08);
        tick <= 1'b1;
        wt(33);
        tick <= 1'b0;
        wt(1);
        cs(1'b1, 5'h1F, SMSR_CODE_WAKE);
        pl(5'h02);
        $display("gate test done");
    endtask : t_gate

    task automatic test_done;
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : test_done

    // ------------------------------------------------------------
    // clock, monitors and main sequence
    // ------------------------------------------------------------
    initial
    begin
        mclk_i = 1'b0;
        forever #12.5 mclk_i = ~mclk_i;
    end
    // counts debounce pulses seen on settled edges
    always @(posedge mclk_i)
        if (dbc === 1'b1)
            dbc_n++;
    // cut a hang short well beyond the few hundred cycles needed
    initial
    begin
        wt(20000);
        fails++;
        test_done;
    end
    initial
    begin
        {nrst_i, strap, trig, motion, sleep_req, meas, tick} = 7'h00;
        bev = 5'h00;
        t_boot;
        t_regs;
        t_modes;
        t_pins;
        t_gate;
        test_done;
    end
endmodule : tb
